// [bsw_ctrl_model.sv]
// Memory controller model that drives the request pins of the burst write path.
module bsw_ctrl_model #(
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic k_phase,
    input wire logic wr_ready,
    input wire logic [35:0] q,
    input wire logic q_oe_n,
    output logic [AW-1:0] addr,
    output logic [35:0] d,
    output logic [3:0] sel_n,
    output logic rps_n,
    output logic wps_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic nxt_comp;
    logic rdy;
    logic [35:0] seen [$];
    initial begin
        addr = '0;
        d = 36'h0;
        sel_n = 4'hF;
        rps_n = 1'h1;
        wps_n = 1'h1;
    end
    // Settled copies taken mid-cycle, so no edge race on K_PHASE
    always @(negedge clk) begin
        nxt_comp <= k_phase;
        rdy <= wr_ready;
        if (q_oe_n === 1'h0) begin
            seen.push_back(q);
        end
    end
    // ****************************************
    // One memory cycle: c0 for the true edge, c1 for the comp edge
    // ****************************************
    task automatic cycle(input logic rd, input logic [AW-1:0] ra, input logic wr,
            input logic [AW-1:0] wa, input logic [71:0] w, input logic [7:0] s,
            input logic bad, output logic ok);
        do @(posedge clk); while (nxt_comp !== 1'h1);
        ok = wr & rdy;
        rps_n <= ~rd;
        wps_n <= ~ok;
        addr <= ra;
        // Idle data lines toggle so a stale beat never looks valid
        d <= ok ? w[35:0] : ~d;
        sel_n <= ok ? s[3:0] : ~sel_n;
        @(posedge clk);
        rps_n <= ~bad;
        wps_n <= ~bad;
        addr <= ok ? wa : ~addr;
        d <= ok ? w[71:36] : ~d;
        sel_n <= ok ? s[7:4] : ~sel_n;
    endtask : cycle
endmodule : bsw_ctrl_model

// [bsw_lane_merge.sv]
// Per-lane merge of a new data word into an old one under active-low lane selects.
module bsw_lane_merge #(
    parameter int LANE_W = 9,
    parameter int LANES = 4
) (
    input wire logic [LANE_W*LANES-1:0] old_word,
    input wire logic [LANE_W*LANES-1:0] new_word,
    input wire logic [LANES-1:0] sel_n,
    output logic [LANE_W*LANES-1:0] merged,
    output logic any_lane
);

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // A high select keeps the stored lane untouched
            assign merged[g*LANE_W +: LANE_W] = sel_n[g] ? old_word[g*LANE_W +: LANE_W]
                                                         : new_word[g*LANE_W +: LANE_W];
        end
    endgenerate

    assign any_lane = ~&sel_n;

endmodule : bsw_lane_merge

// [bsw_pair_buffer.sv]
// Small FIFO with valid/ready on both sides; holds write beats ahead of the array.
module bsw_pair_buffer #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0] slot [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic ready_r;
    logic [CW-1:0] count_nxt;
    wire push = in_valid & ready_r;
    wire pop = out_valid & out_ready;

    assign count_nxt = CW'(count_r + CW'(push) - CW'(pop));
    assign in_ready = ready_r;
    assign out_valid = (count_r != '0);
    assign out_data = slot[rd_ptr_r];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            ready_r <= 1'b1;
        end else begin
            if (push) wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : PW'(wr_ptr_r + 1'b1);
            if (pop) rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : PW'(rd_ptr_r + 1'b1);
            count_r <= count_nxt;
            ready_r <= (count_nxt != FULL_CNT);
        end
    end

    always_ff @(posedge clk) begin
        if (push) slot[wr_ptr_r] <= in_data;
    end

endmodule : bsw_pair_buffer

// [bsw_pkg.sv]
// Shared constants for the burst write path of the two-word-burst SRAM.
package bsw_pkg;

    // ****************************************
    // Geometry defaults
    // ****************************************
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int DATA_W = LANE_W * LANES;
    localparam int ADDR_W = 19;
    localparam int BURST_LEN = 2;
    localparam int BUF_DEPTH = 2;

    // ****************************************
    // Clock
    // ****************************************
    localparam int MCLK_PERIOD_NS = 50;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_OE_N = 1'b1;
    localparam logic RST_FLAG = 1'b0;

    // Which input-clock edge the next MCLK edge stands for
    typedef enum logic {
        PH_TRUE = 1'b0,
        PH_COMP = 1'b1
    } bsw_phase_t;

    localparam bsw_phase_t RST_PHASE = PH_TRUE;

endpackage : bsw_pkg

// [bsw_write_path.sv]
// Top of the burst SRAM data path: beat capture, byte-lane writes and burst reads.
module bsw_write_path #(
    parameter int LANE_W = bsw_pkg::LANE_W,
    parameter int LANES = bsw_pkg::LANES,
    parameter int ADDR_W = bsw_pkg::ADDR_W,
    parameter int BUF_DEPTH = bsw_pkg::BUF_DEPTH
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [LANE_W*LANES-1:0] D,
    input wire logic [LANES-1:0] LANE_WRITE_SELECT_N,
    input wire logic READ_PORT_SELECT_N,
    input wire logic WRITE_PORT_SELECT_N,
    output logic K_PHASE,
    output logic [LANE_W*LANES-1:0] Q,
    output logic Q_OE_N,
    output logic WR_READY
);

    localparam int DW = LANE_W * LANES;
    localparam int MW = ADDR_W + 1;
    localparam int EW = MW + DW + LANES;
    localparam int WORDS = bsw_pkg::BURST_LEN << ADDR_W;

    // ****************************************
    // Edge phase: one MCLK edge per input-clock edge
    // ****************************************
    bsw_pkg::bsw_phase_t ph_r;
    wire k_edge = (ph_r == bsw_pkg::PH_TRUE);
    wire kc_edge = (ph_r == bsw_pkg::PH_COMP);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) ph_r <= bsw_pkg::RST_PHASE;
        else ph_r <= k_edge ? bsw_pkg::PH_COMP : bsw_pkg::PH_TRUE;
    end

    assign K_PHASE = ph_r;

    // ****************************************
    // Write beat capture
    // ****************************************
    logic wr_act_r;
    logic [DW-1:0] b0_data_r;
    logic [LANES-1:0] b0_sel_r;
    logic b1_v_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [DW-1:0] b1_data_r;
    logic [LANES-1:0] b1_sel_r;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_act_r <= bsw_pkg::RST_FLAG;
            b1_v_r <= bsw_pkg::RST_FLAG;
            b0_data_r <= '0;
            b0_sel_r <= '1;
            waddr_r <= '0;
            b1_data_r <= '0;
            b1_sel_r <= '1;
        end else if (k_edge) begin
            wr_act_r <= !WRITE_PORT_SELECT_N;
            b0_data_r <= D;
            b0_sel_r <= LANE_WRITE_SELECT_N;
            b1_v_r <= 1'b0;
        end else begin
            b1_v_r <= wr_act_r;
            if (wr_act_r) begin
                waddr_r <= ADDR;
                b1_data_r <= D;
                b1_sel_r <= LANE_WRITE_SELECT_N;
            end
        end
    end

    // Beat 0 goes in on the complementary edge, beat 1 on the following true edge
    wire buf_in_valid = kc_edge ? wr_act_r : b1_v_r;
    wire [MW-1:0] in_addr = kc_edge ? {ADDR, 1'b0} : {waddr_r, 1'b1};
    wire [DW-1:0] in_data = kc_edge ? b0_data_r : b1_data_r;
    wire [LANES-1:0] in_sel = kc_edge ? b0_sel_r : b1_sel_r;
    wire [EW-1:0] buf_in_word = {in_addr, in_data, in_sel};

    // ****************************************
    // Beat buffer and array write
    // ****************************************
    logic buf_in_ready;
    logic buf_out_valid;
    logic [EW-1:0] buf_out_word;
    logic rd_b_v_r;
    // Array port is shared with the read path; a read slot stalls the drain
    wire drain_ready = !rd_b_v_r;
    wire pop = buf_out_valid & drain_ready;

    bsw_pair_buffer #(
        .W(EW),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(MCLK),
        .rst_n(RST_N),
        .in_valid(buf_in_valid),
        .in_data(buf_in_word),
        .in_ready(buf_in_ready),
        .out_valid(buf_out_valid),
        .out_ready(drain_ready),
        .out_data(buf_out_word)
    );

    assign WR_READY = buf_in_ready;

    wire [MW-1:0] drain_addr = buf_out_word[EW-1 -: MW];
    wire [DW-1:0] drain_data = buf_out_word[LANES +: DW];
    wire [LANES-1:0] drain_sel_n = buf_out_word[LANES-1:0];

    logic [DW-1:0] mem [WORDS];
    logic [DW-1:0] drain_old;
    logic [DW-1:0] drain_merged;
    logic drain_any;

    assign drain_old = mem[drain_addr];

    bsw_lane_merge #(
        .LANE_W(LANE_W),
        .LANES(LANES)
    ) u_merge (
        .old_word(drain_old),
        .new_word(drain_data),
        .sel_n(drain_sel_n),
        .merged(drain_merged),
        .any_lane(drain_any)
    );

    wire drain_write = pop & drain_any;

    always_ff @(posedge MCLK) begin
        if (drain_write) mem[drain_addr] <= drain_merged;
    end

    // ****************************************
    // Read burst pipeline
    // ****************************************
    logic rd_a_v_r;
    logic [ADDR_W-1:0] rd_a_addr_r;
    logic [ADDR_W-1:0] rd_b_addr_r;
    logic [DW-1:0] q_r;
    logic q_oe_n_r;
    wire [DW-1:0] rd_word0 = mem[{rd_b_addr_r, 1'b0}];
    wire [DW-1:0] rd_word1 = mem[{rd_b_addr_r, 1'b1}];

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_a_v_r <= bsw_pkg::RST_FLAG;
            rd_b_v_r <= bsw_pkg::RST_FLAG;
            rd_a_addr_r <= '0;
            rd_b_addr_r <= '0;
            q_r <= '0;
            q_oe_n_r <= bsw_pkg::RST_OE_N;
        end else begin
            q_oe_n_r <= !rd_b_v_r;
            if (k_edge) begin
                rd_a_v_r <= !READ_PORT_SELECT_N;
                rd_a_addr_r <= ADDR;
                rd_b_v_r <= rd_a_v_r;
                rd_b_addr_r <= rd_a_addr_r;
                if (rd_b_v_r) q_r <= rd_word1;
            end else if (rd_b_v_r) begin
                q_r <= rd_word0;
            end
        end
    end

    assign Q = q_r;
    assign Q_OE_N = q_oe_n_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    wire rd_start = k_edge && !READ_PORT_SELECT_N;
    wire wr_start = k_edge && !WRITE_PORT_SELECT_N;

    chk_phase_alternate: assert property (
        ph_r != $past(ph_r) || !$past(RST_N)
    ) else $error("edge phase did not alternate");

    chk_idle_undriven: assert property (
        !rd_b_v_r && !$past(rd_b_v_r) |=> Q_OE_N
    ) else $error("outputs driven with no read pending");

    chk_read_window: assert property (
        rd_start |-> ##4 !Q_OE_N ##1 !Q_OE_N
    ) else $error("read words not driven at t+1 comp and t+2 true");

    chk_read_words: assert property (
        kc_edge && rd_b_v_r |=> (Q == $past(rd_word0)) ##1 (Q == $past(rd_word1))
    ) else $error("read burst words out of order");

    chk_write_sampled: assert property (
        kc_edge |=> wr_act_r == $past(wr_act_r)
    ) else $error("write select taken on the complementary edge");

    chk_beat0_taken: assert property (
        wr_start |=> buf_in_valid && in_data == $past(D) && in_sel == $past(LANE_WRITE_SELECT_N)
    ) else $error("first write word not captured on the true edge");

    chk_beat1_pair: assert property (
        kc_edge && wr_act_r |=> buf_in_valid && in_addr == {$past(ADDR), 1'b1}
                                && in_data == $past(D)
    ) else $error("second beat address or data wrong");

    chk_beat_own_sel: assert property (
        kc_edge && wr_act_r |=> b1_sel_r == $past(LANE_WRITE_SELECT_N)
    ) else $error("second beat did not use its own selects");

    chk_masked_keep: assert property (
        pop && &drain_sel_n |=> mem[$past(drain_addr)] == $past(drain_old)
    ) else $error("fully masked beat changed the array");

    chk_lane_merge: assert property (
        pop && drain_any |=> mem[$past(drain_addr)] == $past(drain_merged)
    ) else $error("selected beat not stored");

    chk_lane0_keep: assert property (
        pop && drain_sel_n[0] |=> mem[$past(drain_addr)][LANE_W-1:0]
                                 == $past(drain_old[LANE_W-1:0])
    ) else $error("deselected lane 0 altered");

    cov_read_burst: cover property (rd_start ##4 !Q_OE_N ##1 !Q_OE_N);
    cov_write_burst: cover property (wr_start ##1 buf_in_valid ##1 buf_in_valid);
    cov_masked_beat: cover property (pop && &drain_sel_n);
    cov_buffer_full: cover property (!buf_in_ready);

endmodule : bsw_write_path

// [bsw_write_path_test.sv]
// Self-checking bench for the burst write path.
module bsw_write_path_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 3;
    localparam int NW = 2 ** (AW + 1);
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic park = 1'h0;
    logic k_phase, q_oe_n, wr_ready, rps_n, wps_n, ok, saw_full;
    logic [AW-1:0] addr;
    logic [35:0] d, q;
    logic [3:0] sel_n;
    logic [35:0] mem [NW];
    logic [35:0] exp_q [$];
    logic [3:0] tbl [6] = '{4'h0, 4'hF, 4'hE, 4'hD, 4'hB, 4'h7};
    int mismatches = 0;
    int total_checks = 0;

    // A parked clock is held high, the quickest state to restart from
    always #25 mclk = park | ~mclk;

    bsw_write_path #(.ADDR_W(AW)) i_dut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .D(d),
        .LANE_WRITE_SELECT_N(sel_n), .READ_PORT_SELECT_N(rps_n),
        .WRITE_PORT_SELECT_N(wps_n), .K_PHASE(k_phase), .Q(q), .Q_OE_N(q_oe_n),
        .WR_READY(wr_ready));
    bsw_ctrl_model #(.AW(AW)) i_ctrl (.clk(mclk), .k_phase(k_phase), .wr_ready(wr_ready),
        .q(q), .q_oe_n(q_oe_n), .addr(addr), .d(d), .sel_n(sel_n), .rps_n(rps_n),
        .wps_n(wps_n));

    // ****************************************
    // Expectation and comparison helpers
    // ****************************************
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
            input logic [3:0] s);
        merge = o;
        for (int g = 0; g < 4; g++) begin
            if (!s[g]) begin
                merge[9*g +: 9] = n[9*g +: 9];
            end
        end
    endfunction : merge

    task automatic cmp(input logic [35:0] e, input logic [35:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp

    task automatic conclude;
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic step(input logic rd, input logic [AW-1:0] ra, input logic wr,
            input logic [AW-1:0] wa, input logic [71:0] w, input logic [7:0] s,
            input logic bad);
        i_ctrl.cycle(rd, ra, wr, wa, w, s, bad, ok);
        if (rd) begin
            exp_q.push_back(mem[{ra, 1'h0}]);
            exp_q.push_back(mem[{ra, 1'h1}]);
        end
        if (ok) begin
            mem[{wa, 1'h0}] = merge(mem[{wa, 1'h0}], w[35:0], s[3:0]);
            mem[{wa, 1'h1}] = merge(mem[{wa, 1'h1}], w[71:36], s[7:4]);
        end
        if (wr & !ok) begin
            saw_full = 1'h1;
        end
    endtask : step

    task automatic drain;
        repeat (4) step(1'h0, '0, 1'h0, '0, 72'h0, 8'hFF, 1'h0);
        @(negedge mclk);
        cmp(36'(exp_q.size()), 36'(i_ctrl.seen.size()));
        while (exp_q.size() > 0 && i_ctrl.seen.size() > 0) begin
            cmp(exp_q.pop_front(), i_ctrl.seen.pop_front());
        end
        exp_q.delete();
        i_ctrl.seen.delete();
        cmp(36'h1, 36'(q_oe_n));
    endtask : drain

    task automatic readall;
        for (int a = 0; a < 2 ** AW; a++) begin
            step(1'h1, a[AW-1:0], 1'h0, '0, 72'h0, 8'hFF, 1'h0);
        end
        drain();
    endtask : readall

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        conclude();
    end

    initial begin
        logic [71:0] w;
        logic [7:0] s;
        void'($urandom(56271));
        saw_full = 1'h0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'h1;
        @(negedge mclk);
        cmp(36'h1, 36'(q_oe_n));
        for (int a = 0; a < 2 ** AW; a++) begin
            w = 72'({$urandom, $urandom, $urandom});
            step(1'h0, '0, 1'h1, a[AW-1:0], w, 8'h00, 1'h0);
        end
        readall();
        // Corner lane patterns first, then random selects; odd rounds add comp-edge select noise
        for (int r = 0; r < 30; r++) begin
            w = 72'({$urandom, $urandom, $urandom});
            s = (r < 6) ? {tbl[5 - r], tbl[r]} : 8'($urandom);
            step(1'h0, '0, 1'h1, AW'($urandom), w, s, 1'(r));
            if (r % 5 == 4) begin
                readall();
            end
        end
        // Reads every cycle stall the array drain so the beat buffer fills
        for (int r = 0; r < 12; r++) begin
            w = 72'({$urandom, $urandom, $urandom});
            step(1'h1, AW'(4 + r % 4), r[0], AW'(r % 4), w, 8'($urandom), 1'h0);
        end
        drain();
        cmp(36'h1, 36'(saw_full));
        // Stop the clock high for a while; the array must keep its contents
        park = 1'h1;
        #510;
        park = 1'h0;
        readall();
        conclude();
    end
endmodule : bsw_write_path_test
